// file: core/vark_defines.svh
`ifndef VARK_DEFINES_SVH
`define VARK_DEFINES_SVH

`define VARK_FUNCT6(w)     w[31:26]
`define VARK_VM_BIT(w)     w[25]
`define VARK_VS2(w)        w[24:20]
`define VARK_VS1(w)        w[19:15]
`define VARK_FUNCT3(w)     w[14:12]
`define VARK_VD(w)         w[11:7]
`define VARK_OPCODE(w)     w[6:0]

`define VARK_F6_VV         6'h28
`define VARK_F6_VS         6'h29
`define VARK_F6_KEY128     6'h22
`define VARK_F6_KEY256     6'h2a
`define VARK_VS1_ENC       5'h02
`define VARK_VS1_ZERO      5'h07
`define VARK_OPMVV         3'h2
`define VARK_OP_VE         7'h77
`define VARK_SEW32         3'h2

`define VARK_GROUP_BITS    16'h0080
`define VARK_GROUP_SHIFT   2
`define VARK_KEY128_MAX    4'hA
`define VARK_KEY256_MIN    4'h2
`define VARK_KEY256_MAX    4'hE

`endif

// file: core/vark_pkg.sv
`default_nettype none
package vark_pkg;

    typedef enum logic [2:0] {
        VARK_IDLE   = 3'b000,
        VARK_READ   = 3'b001,
        VARK_DRAIN  = 3'b010,
        VARK_SETTLE = 3'b011,
        VARK_WRITE  = 3'b100,
        VARK_FIN    = 3'b101
    } vark_state_type;

    typedef enum logic [2:0] {
        VARK_OP_NONE   = 3'b000,
        VARK_OP_ENC    = 3'b001,
        VARK_OP_KEY128 = 3'b010,
        VARK_OP_KEY256 = 3'b011,
        VARK_OP_ZERO   = 3'b100
    } vark_op_type;

endpackage
`default_nettype wire

// file: core/vark_subword.sv
`default_nettype none
module vark_subword
    import vark_pkg::*;
(
    input  wire logic [31:0] i_word,
    output logic      [31:0] o_word
);
    // Forward S-box, entry 0 in the top byte
    localparam logic [2047:0] SBOX = {
        128'h637c_777b_f26b_6fc5_3001_672b_fed7_ab76,
        128'hca82_c97d_fa59_47f0_add4_a2af_9ca4_72c0,
        128'hb7fd_9326_363f_f7cc_34a5_e5f1_71d8_3115,
        128'h04c7_23c3_1896_059a_0712_80e2_eb27_b275,
        128'h0983_2c1a_1b6e_5aa0_523b_d6b3_29e3_2f84,
        128'h53d1_00ed_20fc_b15b_6acb_be39_4a4c_58cf,
        128'hd0ef_aafb_434d_3385_45f9_027f_503c_9fa8,
        128'h51a3_408f_929d_38f5_bcb6_da21_10ff_f3d2,
        128'hcd0c_13ec_5f97_4417_c4a7_7e3d_645d_1973,
        128'h6081_4fdc_222a_9088_46ee_b814_de5e_0bdb,
        128'he032_3a0a_4906_245c_c2d3_ac62_9195_e479,
        128'he7c8_376d_8dd5_4ea9_6c56_f4ea_657a_ae08,
        128'hba78_252e_1ca6_b4c6_e8dd_741f_4bbd_8b8a,
        128'h703e_b566_4803_f60e_6135_57b9_86c1_1d9e,
        128'he1f8_9811_69d9_8e94_9b1e_87e9_ce55_28df,
        128'h8ca1_890d_bfe6_4268_4199_2d0f_b054_bb16
    };

    function automatic logic [7:0] sbox(input logic [7:0] b);
        sbox = SBOX[11'(8 * (255 - int'(b))) +: 8];
    endfunction

    // Pure lookup, no data-dependent timing
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_word[8*k +: 8] = sbox(i_word[8*k +: 8]);
        end
    end
endmodule
`default_nettype wire

// file: core/vark_top.sv
`include "vark_defines.svh"
`default_nettype none
module vark_top
    import vark_pkg::*;
#(
    parameter int VL_W  = 16,
    parameter int IDX_W = 4
) (
    input  wire logic            i_clock,
    input  wire logic            i_rstn,
    input  wire logic            i_issue,
    input  wire logic [31:0]     i_instr,
    input  wire logic [2:0]      i_sew,
    input  wire logic [15:0]     i_group_bits,
    input  wire logic [VL_W-1:0] i_vl,
    input  wire logic [VL_W-1:0] i_vstart,
    input  wire logic [127:0]    i_rd_state,
    input  wire logic [127:0]    i_rd_key,
    output logic                 o_ready,
    output logic [4:0]           o_vd_reg,
    output logic [4:0]           o_vs2_reg,
    output logic                 o_rd_en,
    output logic [IDX_W-1:0]     o_rd_state_idx,
    output logic [IDX_W-1:0]     o_rd_key_idx,
    output logic                 o_wr_en,
    output logic [IDX_W-1:0]     o_wr_idx,
    output logic [127:0]         o_wr_data,
    output logic                 o_retire,
    output logic                 o_fail
);
    localparam int GROUPS = 2 ** IDX_W;

    function automatic logic [7:0] xtime(input logic [7:0] b);
        xtime = {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
    endfunction

    function automatic logic [31:0] rot_word(input logic [31:0] w);
        rot_word = {w[7:0], w[31:8]};
    endfunction

    function automatic logic [31:0] rcon(input logic [3:0] r);
        case (r)
            4'h0:    rcon = 32'h0000_0001;
            4'h1:    rcon = 32'h0000_0002;
            4'h2:    rcon = 32'h0000_0004;
            4'h3:    rcon = 32'h0000_0008;
            4'h4:    rcon = 32'h0000_0010;
            4'h5:    rcon = 32'h0000_0020;
            4'h6:    rcon = 32'h0000_0040;
            4'h7:    rcon = 32'h0000_0080;
            4'h8:    rcon = 32'h0000_001b;
            4'h9:    rcon = 32'h0000_0036;
            default: rcon = 32'h0000_0000;
        endcase
    endfunction

    // Byte (row r, column c) sits at 4c+r
    function automatic logic [127:0] shift_rows(input logic [127:0] s);
        shift_rows = '0;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                shift_rows[8*(4*c+r) +: 8] = s[8*(4*((c+r)%4)+r) +: 8];
            end
        end
    endfunction

    function automatic logic [127:0] mix_columns(input logic [127:0] s);
        logic [7:0] a0;
        logic [7:0] a1;
        logic [7:0] a2;
        logic [7:0] a3;
        mix_columns = '0;
        for (int c = 0; c < 4; c++) begin
            a0 = s[32*c +: 8];
            a1 = s[32*c+8 +: 8];
            a2 = s[32*c+16 +: 8];
            a3 = s[32*c+24 +: 8];
            mix_columns[32*c +: 8]    = xtime(a0) ^ xtime(a1) ^ a1 ^ a2 ^ a3;
            mix_columns[32*c+8 +: 8]  = a0 ^ xtime(a1) ^ xtime(a2) ^ a2 ^ a3;
            mix_columns[32*c+16 +: 8] = a0 ^ a1 ^ xtime(a2) ^ xtime(a3) ^ a3;
            mix_columns[32*c+24 +: 8] = xtime(a0) ^ a0 ^ a1 ^ a2 ^ xtime(a3);
        end
    endfunction

    // Word 0 from t and base word 0, later words chain on base
    function automatic logic [127:0] key_chain(input logic [31:0] t, input logic [127:0] base);
        logic [31:0] w;
        key_chain = '0;
        w = t ^ base[31:0];
        key_chain[31:0] = w;
        for (int k = 1; k < 4; k++) begin
            w = w ^ base[32*k +: 32];
            key_chain[32*k +: 32] = w;
        end
    endfunction

    vark_state_type  state_q;
    vark_op_type     op_q;
    logic            vs_form_q;
    logic [3:0]      rnd_q;
    logic            fail_q;
    logic [VL_W-1:0] idx_q;
    logic [VL_W-1:0] start_q;
    logic [VL_W-1:0] end_q;
    logic            rd_en_q;
    logic [IDX_W-1:0] rd_state_idx_q;
    logic [IDX_W-1:0] rd_key_idx_q;
    logic            cap_q;
    logic [IDX_W-1:0] cap_idx_q;
    logic [127:0]    result_q [GROUPS];
    logic            wr_en_q;
    logic [IDX_W-1:0] wr_idx_q;
    logic [127:0]    wr_data_q;
    logic            retire_q;
    logic [4:0]      vd_reg_q;
    logic [4:0]      vs2_reg_q;

    // Decode
    vark_op_type     dec_op;
    logic            dec_vs;
    logic            dec_ok;
    logic            illegal;
    logic [3:0]      dec_rnd;
    logic [3:0]      imm;
    logic [4:0]      uimm;
    logic [VL_W-1:0] grp_start;
    logic [VL_W-1:0] grp_end;

    assign uimm = `VARK_VS1(i_instr);
    assign imm = uimm[3:0];
    assign grp_start = i_vstart >> `VARK_GROUP_SHIFT;
    assign grp_end = i_vl >> `VARK_GROUP_SHIFT;

    assign dec_ok = `VARK_VM_BIT(i_instr) && (`VARK_FUNCT3(i_instr) == `VARK_OPMVV)
                    && (`VARK_OPCODE(i_instr) == `VARK_OP_VE);

    always_comb begin
        dec_op = VARK_OP_NONE;
        dec_vs = 1'b0;
        if (dec_ok) begin
            if (`VARK_FUNCT6(i_instr) == `VARK_F6_KEY128) begin
                dec_op = VARK_OP_KEY128;
            end else if (`VARK_FUNCT6(i_instr) == `VARK_F6_KEY256) begin
                dec_op = VARK_OP_KEY256;
            end else if (`VARK_VS1(i_instr) == `VARK_VS1_ENC) begin
                if (`VARK_FUNCT6(i_instr) == `VARK_F6_VV) begin
                    dec_op = VARK_OP_ENC;
                end else if (`VARK_FUNCT6(i_instr) == `VARK_F6_VS) begin
                    dec_op = VARK_OP_ENC;
                    dec_vs = 1'b1;
                end
            end else if (`VARK_VS1(i_instr) == `VARK_VS1_ZERO) begin
                if (`VARK_FUNCT6(i_instr) == `VARK_F6_VS) begin
                    dec_op = VARK_OP_ZERO;
                    dec_vs = 1'b1;
                end
            end
        end
    end

    // Out-of-range round numbers fold by flipping bit 3
    always_comb begin
        dec_rnd = imm;
        if (dec_op == VARK_OP_KEY128) begin
            if (imm > `VARK_KEY128_MAX || imm == 4'h0) begin
                dec_rnd = {~imm[3], imm[2:0]};
            end
        end else if (dec_op == VARK_OP_KEY256) begin
            if (imm < `VARK_KEY256_MIN || imm > `VARK_KEY256_MAX) begin
                dec_rnd = {~imm[3], imm[2:0]};
            end
        end
    end

    always_comb begin
        illegal = 1'b0;
        if (dec_op == VARK_OP_NONE) begin
            illegal = 1'b1;
        end
        if (i_sew != `VARK_SEW32) begin
            illegal = 1'b1;
        end
        if (i_group_bits < `VARK_GROUP_BITS) begin
            illegal = 1'b1;
        end
        if (dec_op == VARK_OP_ZERO && i_vstart[1:0] != 2'b00) begin
            illegal = 1'b1;
        end
    end

    assign o_ready = (state_q == VARK_IDLE);

    // Sequencer: fixed walk over the group range
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q   <= VARK_IDLE;
            op_q      <= VARK_OP_NONE;
            vs_form_q <= 1'b0;
            rnd_q     <= 4'h0;
            fail_q    <= 1'b0;
            idx_q     <= '0;
            start_q   <= '0;
            end_q     <= '0;
            vd_reg_q  <= 5'h00;
            vs2_reg_q <= 5'h00;
        end else begin
            case (state_q)
                VARK_IDLE: begin
                    if (i_issue) begin
                        op_q      <= dec_op;
                        vs_form_q <= dec_vs;
                        rnd_q     <= dec_rnd;
                        idx_q     <= grp_start;
                        start_q   <= grp_start;
                        end_q     <= grp_end;
                        vd_reg_q  <= `VARK_VD(i_instr);
                        vs2_reg_q <= `VARK_VS2(i_instr);
                        fail_q    <= illegal;
                        if (illegal || grp_start >= grp_end) begin
                            state_q <= VARK_FIN;
                        end else begin
                            state_q <= VARK_READ;
                        end
                    end
                end
                VARK_READ: begin
                    if (idx_q == end_q - 1'b1) begin
                        idx_q   <= start_q;
                        state_q <= VARK_DRAIN;
                    end else begin
                        idx_q <= idx_q + 1'b1;
                    end
                end
                VARK_DRAIN: begin
                    state_q <= VARK_SETTLE;
                end
                VARK_SETTLE: begin
                    state_q <= VARK_WRITE;
                end
                VARK_WRITE: begin
                    if (idx_q == end_q - 1'b1) begin
                        state_q <= VARK_FIN;
                    end else begin
                        idx_q <= idx_q + 1'b1;
                    end
                end
                VARK_FIN: begin
                    state_q <= VARK_IDLE;
                end
                default: begin
                    state_q <= VARK_IDLE;
                end
            endcase
        end
    end

    // Read port
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_en_q        <= 1'b0;
            rd_state_idx_q <= '0;
            rd_key_idx_q   <= '0;
        end else begin
            rd_en_q <= (state_q == VARK_READ);
            if (state_q == VARK_READ) begin
                rd_state_idx_q <= idx_q[IDX_W-1:0];
                rd_key_idx_q   <= vs_form_q ? '0 : idx_q[IDX_W-1:0];
            end
        end
    end

    // Datapath on the returned groups
    logic [127:0] sub_state;
    logic [31:0]  sub_key;
    logic [127:0] result;
    logic [31:0]  key_t;
    logic [3:0]   rnd_m1;
    logic [3:0]   rnd_half;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_sub
            vark_subword u_sub (
                .i_word (i_rd_state[32*g +: 32]),
                .o_word (sub_state[32*g +: 32])
            );
        end
    endgenerate

    vark_subword u_sub_key (
        .i_word (i_rd_key[127:96]),
        .o_word (sub_key)
    );

    assign rnd_m1 = rnd_q - 4'h1;
    assign rnd_half = {1'b0, rnd_q[3:1]} - 4'h1;

    // Byte substitution commutes with word rotation
    always_comb begin
        key_t = 32'h0000_0000;
        result = 128'h0;
        case (op_q)
            VARK_OP_ENC: begin
                result = mix_columns(shift_rows(sub_state)) ^ i_rd_key;
            end
            VARK_OP_KEY128: begin
                key_t = rot_word(sub_key) ^ rcon(rnd_m1);
                result = key_chain(key_t, i_rd_key);
            end
            VARK_OP_KEY256: begin
                if (rnd_q[0]) begin
                    key_t = sub_key;
                end else begin
                    key_t = rot_word(sub_key) ^ rcon(rnd_half);
                end
                result = key_chain(key_t, i_rd_state);
            end
            VARK_OP_ZERO: begin
                result = i_rd_state ^ i_rd_key;
            end
            default: begin
                result = 128'h0;
            end
        endcase
    end

    // Results parked until every read is done
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cap_q     <= 1'b0;
            cap_idx_q <= '0;
        end else begin
            cap_q     <= rd_en_q;
            cap_idx_q <= rd_state_idx_q;
        end
    end

    always_ff @(posedge i_clock) begin
        if (cap_q) begin
            result_q[cap_idx_q] <= result;
        end
    end

    // Write port
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_en_q   <= 1'b0;
            wr_idx_q  <= '0;
            wr_data_q <= 128'h0;
        end else begin
            wr_en_q <= (state_q == VARK_WRITE);
            if (state_q == VARK_WRITE) begin
                wr_idx_q  <= idx_q[IDX_W-1:0];
                wr_data_q <= result_q[idx_q[IDX_W-1:0]];
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            retire_q <= 1'b0;
        end else begin
            retire_q <= (state_q == VARK_FIN);
        end
    end

    assign o_vd_reg       = vd_reg_q;
    assign o_vs2_reg      = vs2_reg_q;
    assign o_rd_en        = rd_en_q;
    assign o_rd_state_idx = rd_state_idx_q;
    assign o_rd_key_idx   = rd_key_idx_q;
    assign o_wr_en        = wr_en_q;
    assign o_wr_idx       = wr_idx_q;
    assign o_wr_data      = wr_data_q;
    assign o_retire       = retire_q;
    assign o_fail         = fail_q;
endmodule
`default_nettype wire

// file: core/vark_unused_placeholder.sv
`default_nettype none
`default_nettype wire

// file: tb/vark_checker_assertions.sv
`default_nettype none
module vark_checker
    import vark_pkg::*;
#(
    parameter int VL_W  = 16,
    parameter int IDX_W = 4
) (
    input wire logic             i_clock,
    input wire logic             i_rstn,
    input wire logic             i_issue,
    input wire logic [31:0]      i_instr,
    input wire logic [2:0]       i_sew,
    input wire logic [15:0]      i_group_bits,
    input wire logic [VL_W-1:0]  i_vl,
    input wire logic [VL_W-1:0]  i_vstart,
    input wire logic             o_ready,
    input wire logic             o_rd_en,
    input wire logic [IDX_W-1:0] o_rd_state_idx,
    input wire logic [IDX_W-1:0] o_rd_key_idx,
    input wire logic             o_wr_en,
    input wire logic [IDX_W-1:0] o_wr_idx,
    input wire logic             o_retire,
    input wire logic             o_fail
);
    logic            take_w;
    logic [5:0]      f6_q;
    logic [VL_W-1:0] lo_q;
    logic [VL_W-1:0] hi_q;
    logic [VL_W+1:0] cnt_q;
    logic [VL_W+1:0] exp_w;
    logic            wrote_q;

    assign take_w = i_issue && o_ready;
    // Legal retire time: twice the group count plus four, or two when empty
    assign exp_w  = (hi_q > lo_q) ? {1'b0, hi_q - lo_q, 1'b0} + (VL_W+2)'(4) : (VL_W+2)'(2);

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            f6_q    <= 6'h00;
            lo_q    <= '0;
            hi_q    <= '0;
            cnt_q   <= '0;
            wrote_q <= 1'b0;
        end else if (take_w) begin
            f6_q    <= i_instr[31:26];
            lo_q    <= i_vstart >> 2;
            hi_q    <= i_vl >> 2;
            // Issue edge counts as the first
            cnt_q   <= (VL_W+2)'(1);
            wrote_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_q + 1'b1;
            wrote_q <= wrote_q | o_wr_en;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    bad_width_a:
        assert property (take_w && i_sew != 3'h2 |-> ##2 (o_retire && o_fail)) else $error("width not trapped");
    short_group_a:
        assert property (take_w && i_group_bits < 16'h0080 |-> ##2 (o_retire && o_fail))
        else $error("short group not trapped");
    zero_align_a:
        assert property (take_w && i_instr[31:25] == 7'h53 && i_instr[19:15] == 5'h07 && i_vstart[1:0] != 2'h0
            |-> ##2 (o_retire && o_fail)) else $error("misaligned start not trapped");
    retire_time_a:
        assert property (o_retire && !o_fail |-> cnt_q == exp_w) else $error("retire time wrong");
    read_first_a:
        assert property (o_rd_en |-> !wrote_q) else $error("read after write");
    group_range_a:
        assert property (o_wr_en |-> o_wr_idx >= lo_q && o_wr_idx < hi_q) else $error("write outside range");
    shared_key_a:
        assert property (o_rd_en && f6_q == 6'h29 |-> o_rd_key_idx == '0) else $error("scalar key index");
    own_key_a:
        assert property (o_rd_en && f6_q == 6'h28 |-> o_rd_key_idx == o_rd_state_idx) else $error("key index");
    fail_quiet_a:
        assert property (o_fail |-> !o_wr_en && !o_rd_en) else $error("access after trap");
endmodule

bind vark_top vark_checker #(.VL_W(VL_W), .IDX_W(IDX_W)) chk_u (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_issue(i_issue), .i_instr(i_instr), .i_sew(i_sew),
    .i_group_bits(i_group_bits), .i_vl(i_vl), .i_vstart(i_vstart), .o_ready(o_ready), .o_rd_en(o_rd_en),
    .o_rd_state_idx(o_rd_state_idx), .o_rd_key_idx(o_rd_key_idx), .o_wr_en(o_wr_en), .o_wr_idx(o_wr_idx),
    .o_retire(o_retire), .o_fail(o_fail)
);
`default_nettype wire

// file: tb/vark_rf_model.sv
`default_nettype none
module vark_rf_model
    import vark_pkg::*;
#(
    parameter int IDX_W = 4
) (
    input  wire logic             i_clock,
    input  wire logic             i_rd_en,
    input  wire logic [IDX_W-1:0] i_state_idx,
    input  wire logic [IDX_W-1:0] i_key_idx,
    input  wire logic             i_wr_en,
    input  wire logic [IDX_W-1:0] i_wr_idx,
    input  wire logic [127:0]     i_wr_data,
    output var logic  [127:0]     o_state,
    output var logic  [127:0]     o_key
);
    timeunit 1ns;
    timeprecision 1ps;
    // Destination and key storage never alias
    logic [127:0] state_mem [2**IDX_W];
    logic [127:0] key_mem [2**IDX_W];

    initial begin
        o_state = '0;
        o_key = '0;
    end

    // Data valid one cycle after the read, scrambled otherwise
    always @(posedge i_clock) begin
        if (i_rd_en) begin
            o_state <= state_mem[i_state_idx];
            o_key <= key_mem[i_key_idx];
        end else begin
            o_state <= ~o_state;
            o_key <= ~o_key;
        end
        if (i_wr_en) begin
            state_mem[i_wr_idx] <= i_wr_data;
        end
    end
endmodule
`default_nettype wire

// file: tb/vark_top_tb.sv
`default_nettype none
module vark_top_tb
    import vark_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic         i_clock = 1'b0;
    logic         i_rstn = 1'b0;
    logic         i_issue = 1'b0;
    logic [31:0]  i_instr = 32'h0000_0000;
    logic [2:0]   i_sew = 3'h2;
    logic [15:0]  i_group_bits = 16'h0080;
    logic [15:0]  i_vl = 16'h0000;
    logic [15:0]  i_vstart = 16'h0000;
    logic [127:0] rd_state, rd_key, wr_data, s_v, k0_v, k1_v, e_v, d_v;
    logic [3:0]   rs_idx, rk_idx, wr_idx;
    logic         o_ready, o_rd_en, o_wr_en, o_retire, o_fail;
    logic [4:0]   vd_reg, vs2_reg;
    int           n_mismatch = 0;
    int           comparisons = 0;

    always #20 i_clock = ~i_clock;

    vark_top #(.VL_W(16), .IDX_W(4)) dut_u (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_issue(i_issue), .i_instr(i_instr), .i_sew(i_sew),
        .i_group_bits(i_group_bits), .i_vl(i_vl), .i_vstart(i_vstart), .i_rd_state(rd_state),
        .i_rd_key(rd_key), .o_ready(o_ready), .o_vd_reg(vd_reg), .o_vs2_reg(vs2_reg), .o_rd_en(o_rd_en),
        .o_rd_state_idx(rs_idx), .o_rd_key_idx(rk_idx), .o_wr_en(o_wr_en), .o_wr_idx(wr_idx),
        .o_wr_data(wr_data), .o_retire(o_retire), .o_fail(o_fail)
    );

    vark_rf_model #(.IDX_W(4)) rf_u (
        .i_clock(i_clock), .i_rd_en(o_rd_en), .i_state_idx(rs_idx), .i_key_idx(rk_idx), .i_wr_en(o_wr_en),
        .i_wr_idx(wr_idx), .i_wr_data(wr_data), .o_state(rd_state), .o_key(rd_key)
    );

    // Byte 0 of the AES block sits in the low byte
    function automatic logic [127:0] le(input logic [127:0] b);
        for (int i = 0; i < 16; i++) le[8*i +: 8] = b[127-8*i -: 8];
    endfunction

    // Destination register 4, key register 8, kept apart
    function automatic logic [31:0] op(input logic [5:0] f6, input logic [4:0] v1);
        return {f6, 1'b1, 5'h08, v1, 3'h2, 5'h04, 7'h77};
    endfunction

    task automatic check(input logic [127:0] seen, input logic [127:0] want);
        comparisons++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic load(input int g, input logic [127:0] s, input logic [127:0] k);
        rf_u.state_mem[g] = s;
        rf_u.key_mem[g] = k;
    endtask

    task automatic run(input logic [31:0] ins, input logic [2:0] sew, input logic [15:0] gb,
                       input logic [15:0] vl, input logic [15:0] vs, input logic fl, input int lat);
        int k;
        // Counted at the edge that samples retire high
        k = 1;
        @(posedge i_clock);
        i_instr <= ins;
        i_sew <= sew;
        i_group_bits <= gb;
        i_vl <= vl;
        i_vstart <= vs;
        i_issue <= 1'b1;
        @(posedge i_clock);
        i_issue <= 1'b0;
        do begin
            @(posedge i_clock);
            #1;
            k++;
        end while (o_retire !== 1'b1 && k < 64);
        check(128'(k), 128'(lat));
        check(o_fail, fl);
        check(vd_reg, ins[11:7]);
        check(vs2_reg, ins[24:20]);
        check(o_ready, 1'b1);
    endtask

    task automatic t_enc();
        load(0, s_v, k1_v);
        load(1, s_v, 128'h0);
        run(op(6'h28, 5'h02), 3'h2, 16'h0080, 16'h0008, 16'h0000, 1'b0, 8);
        check(rf_u.state_mem[0], e_v);
        check(rf_u.state_mem[1], e_v ^ k1_v);
        load(0, k0_v, k1_v);
        load(1, s_v, k0_v);
        load(2, s_v, ~k1_v);
        load(3, s_v, k0_v);
        run(op(6'h29, 5'h02), 3'h2, 16'h0100, 16'h000d, 16'h0005, 1'b0, 8);
        check(rf_u.state_mem[0], k0_v);
        check(rf_u.state_mem[1], e_v);
        check(rf_u.state_mem[2], e_v);
        check(rf_u.state_mem[3], s_v);
    endtask

    task automatic t_key();
        logic [4:0] u1 [8] = '{5'h01, 5'h11, 5'h08, 5'h00, 5'h0b, 5'h0f, 5'h0a, 5'h02};
        logic [7:0] m1 [8] = '{8'h00, 8'h00, 8'h81, 8'h81, 8'h05, 8'h41, 8'h37, 8'h03};
        logic [4:0] u2 [9] = '{5'h02, 5'h04, 5'h00, 5'h0e, 5'h12, 5'h0c, 5'h01, 5'h03, 5'h0f};
        logic [7:0] m2 [9] = '{8'h00, 8'h03, 8'h09, 8'h41, 8'h00, 8'h21, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            load(0, ~k0_v, k0_v);
            run(op(6'h22, u1[i]), 3'h2, 16'h0080, 16'h0004, 16'h0000, 1'b0, 6);
            check(rf_u.state_mem[0], k1_v ^ {4{24'h00_0000, m1[i]}});
        end
        for (int i = 0; i < 9; i++) begin
            load(0, k0_v, k0_v);
            run(op(6'h2a, u2[i]), 3'h2, 16'h0080, 16'h0004, 16'h0000, 1'b0, 6);
            check(rf_u.state_mem[0], (i < 6) ? k1_v ^ {4{24'h00_0000, m2[i]}} : d_v);
        end
    endtask

    task automatic t_zero();
        load(0, s_v, k1_v);
        load(1, k0_v, s_v);
        run(op(6'h29, 5'h07), 3'h2, 16'h0080, 16'h0008, 16'h0000, 1'b0, 8);
        check(rf_u.state_mem[0], s_v ^ k1_v);
        check(rf_u.state_mem[1], k0_v ^ k1_v);
        run(op(6'h29, 5'h07), 3'h2, 16'h0080, 16'h0008, 16'h0002, 1'b1, 2);
        check(rf_u.state_mem[0], s_v ^ k1_v);
    endtask

    task automatic t_illegal();
        run(op(6'h28, 5'h02), 3'h3, 16'h0080, 16'h0008, 16'h0000, 1'b1, 2);
        run(op(6'h28, 5'h02), 3'h2, 16'h007f, 16'h0008, 16'h0000, 1'b1, 2);
        run(op(6'h28, 5'h02), 3'h2, 16'h0080, 16'h0007, 16'h0004, 1'b0, 2);
        run(op(6'h28, 5'h07), 3'h2, 16'h0080, 16'h0008, 16'h0000, 1'b1, 2);
        check(rf_u.state_mem[0], s_v ^ k1_v);
    endtask

    initial begin
        s_v = le(128'h193de3be_a0f4e22b_9ac68d2a_e9f84808);
        k0_v = le(128'h2b7e1516_28aed2a6_abf71588_09cf4f3c);
        k1_v = le(128'ha0fafe17_88542cb1_23a33939_2a6c7605);
        e_v = le(128'ha49c7ff2_689f352b_6b5bea43_026a5049);
        d_v = le(128'h2af491fd_025a435b_a9ad56d3_a06219ef);
        repeat (8) @(posedge i_clock);
        i_rstn <= 1'b1;
        t_enc();
        t_key();
        t_zero();
        t_illegal();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
